// [sag_params.svh]
`ifndef SAG_PARAMS_SVH
`define SAG_PARAMS_SVH

// ****************************************************************
// clock and link timing
// ****************************************************************
`define SAG_CLK_KHZ 40000
`define SAG_FM_SCL_KHZ 400
`define SAG_HS_SCL_KHZ 3400
// one bit of the controller takes this many equal phases
`define SAG_PHASES 3
// shortest allowed phase rounds up so the clock never runs too fast
`define SAG_FM_PHASE_CYC ((`SAG_CLK_KHZ + `SAG_PHASES * `SAG_FM_SCL_KHZ - 1) / (`SAG_PHASES * `SAG_FM_SCL_KHZ))
`define SAG_HS_PHASE_CYC ((`SAG_CLK_KHZ + `SAG_PHASES * `SAG_HS_SCL_KHZ - 1) / (`SAG_PHASES * `SAG_HS_SCL_KHZ))
// spike suppression of the device input filters, cycle count rounds down but never below one
`define SAG_FM_SPIKE_NS 50
`define SAG_HS_SPIKE_NS 10
`define SAG_NS_CYC(ns) (((ns) * `SAG_CLK_KHZ / 1000000) > 0 ? ((ns) * `SAG_CLK_KHZ / 1000000) : 1)
`define SAG_FM_FILT_CYC `SAG_NS_CYC(`SAG_FM_SPIKE_NS)
`define SAG_HS_FILT_CYC `SAG_NS_CYC(`SAG_HS_SPIKE_NS)

// ****************************************************************
// bus codes
// ****************************************************************
`define SAG_ARA_BYTE 8'h19
`define SAG_GC_BYTE 8'h00
`define SAG_GC_LATCH 8'h04
`define SAG_GC_RESET 8'h06
`define SAG_HS_CODE 5'h01
`define SAG_ADDR_BASE 4'h9
`define SAG_PIN_LO 2'h0
`define SAG_PIN_HI 2'h1
`define SAG_PIN_FLT 2'h2

// ****************************************************************
// controller register map
// ****************************************************************
`define SAG_CTRL_OFS 12'h000
`define SAG_STAT_OFS 12'h004
`define SAG_CTRL_CMD_LSB 8
`define SAG_CTRL_NACK_BIT 10
`define SAG_STAT_NACK_BIT 8
`define SAG_STAT_BUSY_BIT 9
`define SAG_STAT_ALERT_BIT 10
`define SAG_STAT_HS_BIT 11

`endif

// [sag_pkg.sv]
package sag_pkg;
  typedef enum logic [2:0] {DS_IDLE, DS_ADDR, DS_ACK, DS_RX, DS_TX, DS_TXACK, DS_WAIT} sag_dstate_type;
  typedef enum logic [1:0] {DK_WR, DK_RD, DK_GC, DK_ARA} sag_kind_type;
  typedef enum logic [1:0] {SC_START, SC_STOP, SC_WRITE, SC_READ} sag_cmd_type;
  typedef enum logic [1:0] {MS_IDLE, MS_START, MS_STOP, MS_BIT} sag_mstate_type;
endpackage

// [sag_if.sv]
`timescale 1ns/10ps
// ****************************************************************
// open-drain two-wire link plus shared alert line
// ****************************************************************
interface sag_if;
  logic m_scl_oe;
  logic m_sda_oe;
  logic d_sda_oe;
  logic d_alert_oe;
  logic scl;
  logic sda;
  logic alert_n;
  // wired-and: a line is low while any party enables its driver
  assign scl = ~m_scl_oe;
  assign sda = ~(m_sda_oe | d_sda_oe);
  assign alert_n = ~d_alert_oe;
  modport dev (input scl, input sda, output d_sda_oe, output d_alert_oe);
  modport mst (input scl, input sda, input alert_n, output m_scl_oe, output m_sda_oe);
endinterface

// [sag_master.sv]
`timescale 1ns/10ps
`include "sag_params.svh"

module sag_master import sag_pkg::*; (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  sag_if.mst link
);
  logic sda_s1_r, sda_s2_r, alert_s1_r, alert_s2_r;
  logic pready_r, pslverr_r, scl_oe_r, sda_oe_r, hs_r, first_r;
  logic [31:0] prdata_r;
  logic [7:0] tmr_r, phase_w;
  logic [1:0] step_r;
  logic [3:0] bit_r;
  logic [8:0] out_r, in_r;
  sag_mstate_type st_r;
  sag_cmd_type cmd_w;
  logic setup_w, hit_w, wr_w, tick_w;
  logic [31:0] status_w;

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign link.m_scl_oe = scl_oe_r;
  assign link.m_sda_oe = sda_oe_r;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
      alert_s1_r <= 1'b1;
      alert_s2_r <= 1'b1;
    end else begin
      sda_s1_r <= link.sda;
      sda_s2_r <= sda_s1_r;
      alert_s1_r <= link.alert_n;
      alert_s2_r <= alert_s1_r;
    end
  end

  // ****************************************************************
  // apb slave: one access cycle, no wait states
  // ****************************************************************
  assign setup_w = psel & ~penable;
  assign hit_w = (paddr == `SAG_CTRL_OFS) || (paddr == `SAG_STAT_OFS);
  assign wr_w = psel & penable & pready_r & pwrite & (paddr == `SAG_CTRL_OFS);
  assign cmd_w = sag_cmd_type'(pwdata[`SAG_CTRL_CMD_LSB +: 2]);
  always_comb begin
    status_w = '0;
    status_w[7:0] = in_r[8:1];
    status_w[`SAG_STAT_NACK_BIT] = in_r[0];
    status_w[`SAG_STAT_BUSY_BIT] = (st_r != MS_IDLE);
    status_w[`SAG_STAT_ALERT_BIT] = ~alert_s2_r;
    status_w[`SAG_STAT_HS_BIT] = hs_r;
  end

  // answer is registered in the setup cycle so prdata comes from a flop
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= setup_w;
      pslverr_r <= setup_w & ~hit_w;
      prdata_r <= (setup_w && !pwrite && paddr == `SAG_STAT_OFS) ? status_w : 32'h0000_0000;
    end
  end

  // ****************************************************************
  // phase timer, rate depends on high-speed state
  // ****************************************************************
  assign phase_w = hs_r ? 8'(`SAG_HS_PHASE_CYC) : 8'(`SAG_FM_PHASE_CYC);
  assign tick_w = (tmr_r == 8'h00);
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tmr_r <= 8'h00;
    end else if (st_r == MS_IDLE || tick_w) begin
      tmr_r <= phase_w - 8'h01;
    end else begin
      tmr_r <= tmr_r - 8'h01;
    end
  end

  // ****************************************************************
  // bus sequencer; commands while busy are dropped, software polls busy
  // ****************************************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= MS_IDLE;
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
      step_r <= 2'd0;
      bit_r <= 4'd0;
      out_r <= 9'h1FF;
      in_r <= 9'h000;
      hs_r <= 1'b0;
      first_r <= 1'b0;
    end else begin
      unique case (st_r)
        MS_IDLE: begin
          if (wr_w) begin
            step_r <= 2'd0;
            bit_r <= 4'd0;
            // a read sends ack or nack in the ninth bit
            out_r <= (cmd_w == SC_WRITE) ? {pwdata[7:0], 1'b1} : {8'hFF, pwdata[`SAG_CTRL_NACK_BIT]};
            unique case (cmd_w)
              SC_START: st_r <= MS_START;
              SC_STOP: st_r <= MS_STOP;
              SC_WRITE, SC_READ: st_r <= MS_BIT;
            endcase
          end
        end
        MS_START: if (tick_w) begin
          step_r <= step_r + 2'd1;
          unique case (step_r)
            2'd0: sda_oe_r <= 1'b0;
            2'd1: scl_oe_r <= 1'b0;
            2'd2: sda_oe_r <= 1'b1;
            2'd3: begin
              scl_oe_r <= 1'b1;
              first_r <= 1'b1;
              st_r <= MS_IDLE;
            end
          endcase
        end
        MS_STOP: if (tick_w) begin
          step_r <= step_r + 2'd1;
          unique case (step_r)
            2'd0: sda_oe_r <= 1'b1;
            2'd1: scl_oe_r <= 1'b0;
            default: begin
              sda_oe_r <= 1'b0;
              hs_r <= 1'b0;
              st_r <= MS_IDLE;
            end
          endcase
        end
        MS_BIT: if (tick_w) begin
          step_r <= (step_r == 2'd2) ? 2'd0 : step_r + 2'd1;
          unique case (step_r)
            2'd0: sda_oe_r <= ~out_r[8];
            2'd1: scl_oe_r <= 1'b0;
            default: begin
              // sample at the end of the high phase, then pull clock low
              in_r <= {in_r[7:0], sda_s2_r};
              scl_oe_r <= 1'b1;
              out_r <= {out_r[7:0], 1'b1};
              bit_r <= bit_r + 4'd1;
              if (bit_r == 4'd8) begin
                st_r <= MS_IDLE;
                first_r <= 1'b0;
                sda_oe_r <= 1'b0;
                if (first_r && in_r[7:3] == `SAG_HS_CODE) begin
                  hs_r <= 1'b1;
                end
              end
            end
          endcase
        end
      endcase
    end
  end
endmodule

// [sag_device.sv]
`timescale 1ns/10ps
`include "sag_params.svh"

// How it works
// - alert line driven only in interrupt mode
// - active alert acks response address, sends address
// - returned lsb gives cause, polarity inverts it
// - arbitrate; winner clears alert, loser keeps it
// - answers response address only while alert active in interrupt mode
// - ack general call write, next byte command
// - command 04 relatches address pins only
// - command 06 relatches pins and resets registers
// - hs master code unacked, filters go high-speed
// - high-speed lasts until stop, then fast filters
// - master clock at most 0.4/3.4 MHz
// - idle means both lines high, none driven
// - start opens, stop or restart closes
// - unlimited bytes, receiver acks each one
// - ack held low over whole ninth clock
// - master nack ends a read
// - alert holds until read, response or shutdown
// - general call reset clears alert and mode
module sag_device import sag_pkg::*; #(
  parameter int FM_FILT = `SAG_FM_FILT_CYC,
  parameter int HS_FILT = `SAG_HS_FILT_CYC
) (
  input wire logic core_clk,
  input wire logic rst_n,
  sag_if.dev link,
  input wire logic [1:0] addr_select_a,
  input wire logic [1:0] addr_select_b,
  input wire logic cfg_wr,
  input wire logic cfg_mode,
  input wire logic cfg_pol,
  input wire logic alert_set,
  input wire logic alert_cause_low,
  input wire logic reg_read,
  input wire logic shutdown,
  input wire logic [7:0] tx_data,
  output logic alert_mode_select,
  output logic alert_polarity,
  output logic alert_active,
  output logic hs_mode,
  output logic gc_reset,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rd_strobe,
  output logic [6:0] slave_addr
);
  logic [1:0] raw_w, flt_w, prev_r;
  logic [3:0] lim_w;
  logic scl_w, sda_w, scl_rise_w, scl_fall_w, start_w, stop_w;
  logic [3:0] pin_s1_r, pin_s2_r;
  logic latched_r;
  logic [2:0] addr_lo_r;
  sag_dstate_type st_r;
  sag_kind_type kind_r;
  logic [2:0] cnt_r;
  logic [7:0] sh_r, tx_r, byte_w, load_byte_w;
  logic sda_oe_r, alert_oe_r, ackd_r, go_r, first_r;
  logic alert_r, low_r, mode_r, pol_r, hs_r;
  logic last_w, load_w, gc_cmd_w, gc_rst_w, gc_latch_w, ara_done_w;

  assign link.d_sda_oe = sda_oe_r;
  assign link.d_alert_oe = alert_oe_r;
  assign alert_mode_select = mode_r;
  assign alert_polarity = pol_r;
  assign alert_active = alert_r;
  assign hs_mode = hs_r;
  assign slave_addr = {`SAG_ADDR_BASE, addr_lo_r};

  // ****************************************************************
  // input filters: two-flop sync, then a spike filter per line
  // ****************************************************************
  assign raw_w = {link.sda, link.scl};
  assign lim_w = hs_r ? 4'(HS_FILT) : 4'(FM_FILT);
  genvar gi;
  for (gi = 0; gi < 2; gi++) begin : g_filt
    logic s1_r, s2_r, f_r;
    logic [3:0] cnt_f_r;
    assign flt_w[gi] = f_r;
    // a change must persist past the limit before it is believed
    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        s1_r <= 1'b1;
        s2_r <= 1'b1;
        f_r <= 1'b1;
        cnt_f_r <= 4'h0;
      end else begin
        s1_r <= raw_w[gi];
        s2_r <= s1_r;
        if (s2_r == f_r) begin
          cnt_f_r <= 4'h0;
        end else if (cnt_f_r >= lim_w) begin
          f_r <= s2_r;
          cnt_f_r <= 4'h0;
        end else begin
          cnt_f_r <= cnt_f_r + 4'h1;
        end
      end
    end
  end

  // edge and condition detection on the filtered lines
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_r <= 2'b11;
    end else begin
      prev_r <= flt_w;
    end
  end
  assign scl_w = flt_w[0];
  assign sda_w = flt_w[1];
  assign scl_rise_w = scl_w & ~prev_r[0];
  assign scl_fall_w = ~scl_w & prev_r[0];
  assign start_w = scl_w & prev_r[0] & prev_r[1] & ~sda_w;
  assign stop_w = scl_w & prev_r[0] & ~prev_r[1] & sda_w;

  // ****************************************************************
  // address select pins
  // ****************************************************************
  function automatic logic [2:0] pin_map(input logic [1:0] b, input logic [1:0] a);
    unique case ({b, a})
      {`SAG_PIN_LO, `SAG_PIN_FLT}: pin_map = 3'd1;
      {`SAG_PIN_LO, `SAG_PIN_HI}: pin_map = 3'd2;
      {`SAG_PIN_HI, `SAG_PIN_LO}: pin_map = 3'd4;
      {`SAG_PIN_HI, `SAG_PIN_FLT}: pin_map = 3'd5;
      {`SAG_PIN_HI, `SAG_PIN_HI}: pin_map = 3'd6;
      {`SAG_PIN_FLT, `SAG_PIN_LO}: pin_map = 3'd3;
      {`SAG_PIN_FLT, `SAG_PIN_HI}: pin_map = 3'd7;
      default: pin_map = 3'd0;
    endcase
  endfunction

  // pins are latched once to save sensing power, again on general call command 04 or 06
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_r <= 4'h0;
      pin_s2_r <= 4'h0;
      latched_r <= 1'b0;
      addr_lo_r <= 3'd0;
    end else begin
      pin_s1_r <= {addr_select_b, addr_select_a};
      pin_s2_r <= pin_s1_r;
      if ((start_w && !latched_r) || gc_latch_w) begin
        latched_r <= 1'b1;
        addr_lo_r <= pin_map(pin_s2_r[3:2], pin_s2_r[1:0]);
      end
    end
  end

  // ****************************************************************
  // byte decode helpers
  // ****************************************************************
  assign byte_w = {sh_r[6:0], sda_w};
  assign last_w = scl_rise_w && cnt_r == 3'd7 && !start_w && !stop_w;
  assign gc_cmd_w = last_w && st_r == DS_RX && kind_r == DK_GC;
  assign gc_rst_w = gc_cmd_w && byte_w == `SAG_GC_RESET;
  assign gc_latch_w = gc_cmd_w && (byte_w == `SAG_GC_LATCH || byte_w == `SAG_GC_RESET);
  assign ara_done_w = scl_rise_w && st_r == DS_TXACK && kind_r == DK_ARA && !start_w && !stop_w;
  assign load_w = scl_fall_w && !start_w && !stop_w &&
                  ((st_r == DS_ACK && ackd_r && (kind_r == DK_RD || kind_r == DK_ARA)) ||
                   (st_r == DS_TXACK && go_r));
  assign load_byte_w = (kind_r == DK_ARA) ? {slave_addr, low_r ^ pol_r} : tx_data;

  // ****************************************************************
  // protocol engine
  // ****************************************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= DS_IDLE;
      kind_r <= DK_WR;
      cnt_r <= 3'd0;
      sh_r <= 8'h00;
      tx_r <= 8'hFF;
      sda_oe_r <= 1'b0;
      ackd_r <= 1'b0;
      go_r <= 1'b0;
      first_r <= 1'b0;
    end else if (stop_w) begin
      st_r <= DS_IDLE;
      sda_oe_r <= 1'b0;
      go_r <= 1'b0;
    end else if (start_w) begin
      // repeated start also lands here and aborts any transfer
      st_r <= DS_ADDR;
      cnt_r <= 3'd0;
      sda_oe_r <= 1'b0;
      go_r <= 1'b0;
      first_r <= 1'b1;
    end else if (load_w) begin
      sda_oe_r <= ~load_byte_w[7];
      tx_r <= {load_byte_w[6:0], 1'b1};
      cnt_r <= 3'd0;
      ackd_r <= 1'b0;
      go_r <= 1'b0;
      st_r <= DS_TX;
    end else begin
      unique case (st_r)
        DS_IDLE, DS_WAIT: begin
          sda_oe_r <= 1'b0;
        end
        DS_ADDR, DS_RX: if (scl_rise_w) begin
          sh_r <= byte_w;
          cnt_r <= cnt_r + 3'd1;
          if (cnt_r == 3'd7) begin
            first_r <= 1'b0;
            ackd_r <= 1'b0;
            if (st_r == DS_RX) begin
              st_r <= DS_ACK;
            end else if (first_r && byte_w[7:3] == `SAG_HS_CODE) begin
              st_r <= DS_WAIT;
            end else if (byte_w == `SAG_ARA_BYTE) begin
              kind_r <= DK_ARA;
              st_r <= (alert_r && mode_r) ? DS_ACK : DS_WAIT;
            end else if (byte_w == `SAG_GC_BYTE) begin
              kind_r <= DK_GC;
              st_r <= DS_ACK;
            end else if (byte_w[7:1] == slave_addr) begin
              kind_r <= byte_w[0] ? DK_RD : DK_WR;
              st_r <= DS_ACK;
            end else begin
              st_r <= DS_WAIT;
            end
          end
        end
        DS_ACK: if (scl_fall_w) begin
          if (!ackd_r) begin
            sda_oe_r <= 1'b1;
            ackd_r <= 1'b1;
          end else begin
            // released only after the ninth clock has gone low again
            sda_oe_r <= 1'b0;
            ackd_r <= 1'b0;
            cnt_r <= 3'd0;
            st_r <= DS_RX;
          end
        end
        DS_TX: if (scl_rise_w) begin
          cnt_r <= cnt_r + 3'd1;
          if (!sda_oe_r && !sda_w) begin
            st_r <= DS_WAIT;
          end else if (cnt_r == 3'd7) begin
            st_r <= DS_TXACK;
          end
        end else if (scl_fall_w) begin
          sda_oe_r <= ~tx_r[7];
          tx_r <= {tx_r[6:0], 1'b1};
        end
        DS_TXACK: if (scl_fall_w) begin
          sda_oe_r <= 1'b0;
        end else if (scl_rise_w) begin
          if (kind_r == DK_RD && !sda_w) begin
            go_r <= 1'b1;
          end else begin
            st_r <= DS_WAIT;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // user side strobes
  // ****************************************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_valid <= 1'b0;
      rx_data <= 8'h00;
      rd_strobe <= 1'b0;
      gc_reset <= 1'b0;
    end else begin
      rx_valid <= last_w && st_r == DS_RX && kind_r == DK_WR;
      if (last_w && st_r == DS_RX && kind_r == DK_WR) begin
        rx_data <= byte_w;
      end
      rd_strobe <= load_w && kind_r == DK_RD;
      gc_reset <= gc_rst_w;
    end
  end

  // high-speed filters from master code until the next stop
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hs_r <= 1'b0;
    end else if (stop_w) begin
      hs_r <= 1'b0;
    end else if (last_w && st_r == DS_ADDR && first_r && byte_w[7:3] == `SAG_HS_CODE) begin
      hs_r <= 1'b1;
    end
  end

  // ****************************************************************
  // alert flag and mode bits; a new event beats any clear
  // ****************************************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      alert_r <= 1'b0;
      low_r <= 1'b0;
    end else if (alert_set && mode_r) begin
      alert_r <= 1'b1;
      low_r <= alert_cause_low;
    end else if (reg_read || rd_strobe || shutdown || ara_done_w || gc_rst_w) begin
      alert_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_r <= 1'b0;
      pol_r <= 1'b0;
      alert_oe_r <= 1'b0;
    end else begin
      if (gc_rst_w) begin
        mode_r <= 1'b0;
        pol_r <= 1'b0;
      end else if (cfg_wr) begin
        mode_r <= cfg_mode;
        pol_r <= cfg_pol;
      end
      alert_oe_r <= alert_r && mode_r;
    end
  end
endmodule

// [sag_sva.sv]
`timescale 1ns/10ps
`include "sag_params.svh"

module sag_sva (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic m_scl_oe,
  input wire logic m_sda_oe,
  input wire logic d_sda_oe,
  input wire logic d_alert_oe,
  input wire logic scl,
  input wire logic sda,
  input wire logic alert_n
);
  // ****************************************************************
  // bus decoding, edges seen one cycle late so no sampling race
  // ****************************************************************
  logic scl_q, sda_q, busy_r, first_r, ara_r;
  logic [3:0] bit_r;
  logic [7:0] sh_r;
  wire start_ev = scl && scl_q && sda_q && !sda;
  wire stop_ev = scl && scl_q && !sda_q && sda;
  wire rise = scl && !scl_q;
  wire ninth = rise && (bit_r == 4'h8);

  // line history
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end

  // frame open between start and stop
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) busy_r <= 1'b0;
    else if (start_ev) busy_r <= 1'b1;
    else if (stop_ev) busy_r <= 1'b0;
  end

  // bit position, shifted byte and alert-response bookkeeping
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_r <= 4'h0;
      first_r <= 1'b0;
      sh_r <= 8'h00;
      ara_r <= 1'b0;
    end else if (start_ev) begin
      bit_r <= 4'h0;
      first_r <= 1'b1;
      ara_r <= 1'b0;
    end else if (rise) begin
      bit_r <= (bit_r == 4'h8) ? 4'h0 : bit_r + 4'h1;
      if (bit_r != 4'h8) sh_r <= {sh_r[6:0], sda};
      if (bit_r == 4'h8) first_r <= 1'b0;
      if (ninth && first_r) ara_r <= (sh_r == `SAG_ARA_BYTE) && !sda;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // ****************************************************************
  // properties
  // ****************************************************************
  a_idle_quiet: assert property (!busy_r |-> !d_sda_oe)
    else $error("device drives data on idle bus");
  a_sda_steady: assert property (scl && scl_q |-> $stable(d_sda_oe))
    else $error("device moved data while clock high");
  a_ack_held: assert property (ninth && d_sda_oe |-> (d_sda_oe && scl)[*3])
    else $error("acknowledge not held over clock high");
  a_hs_unacked: assert property (ninth && first_r && sh_r[7:3] == 5'h01 |-> !d_sda_oe)
    else $error("high-speed code acknowledged");
  a_ara_acked: assert property (ninth && first_r && sh_r == `SAG_ARA_BYTE && !alert_n
    |-> d_sda_oe)
    else $error("alert response not acknowledged");
  a_ara_quiet: assert property (ninth && first_r && sh_r == `SAG_ARA_BYTE && alert_n
    |-> (!d_sda_oe)[*8])
    else $error("alert response acked without alert");
  a_gc_acked: assert property (ninth && first_r && sh_r == `SAG_GC_BYTE |-> d_sda_oe)
    else $error("general call not acknowledged");
  a_ara_reply: assert property (ninth && !first_r && ara_r
    |-> sh_r[7:4] == `SAG_ADDR_BASE ##[1:8] alert_n)
    else $error("alert reply or alert release wrong");
endmodule

// [test_sensor_i2c_alert_gencall_hs.sv]
`timescale 1ns/10ps
`include "sag_params.svh"

module test_sensor_i2c_alert_gencall_hs import sag_pkg::*;;
  logic core_clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, st, r;
  logic [1:0] pin_a, pin_b;
  logic cfg_wr, cfg_mode, cfg_pol, alert_set, cause_low, reg_read, shutdown;
  logic [7:0] tx_data, rx_data, rx_last;
  logic mode_o, pol_o, alert_act, hs_o, gc_reset, rx_valid, rd_strobe, gc_seen;
  logic [6:0] slave_addr;
  int fails, n_compared, i;

  sag_if link();
  sag_master u_sag_master (.core_clk(core_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link));
  sag_device u_sag_device (.core_clk(core_clk), .rst_n(rst_n), .link(link),
    .addr_select_a(pin_a), .addr_select_b(pin_b), .cfg_wr(cfg_wr), .cfg_mode(cfg_mode),
    .cfg_pol(cfg_pol), .alert_set(alert_set), .alert_cause_low(cause_low),
    .reg_read(reg_read), .shutdown(shutdown), .tx_data(tx_data),
    .alert_mode_select(mode_o), .alert_polarity(pol_o), .alert_active(alert_act),
    .hs_mode(hs_o), .gc_reset(gc_reset), .rx_valid(rx_valid), .rx_data(rx_data),
    .rd_strobe(rd_strobe), .slave_addr(slave_addr));
  sag_sva u_sag_sva (.core_clk(core_clk), .rst_n(rst_n), .m_scl_oe(link.m_scl_oe),
    .m_sda_oe(link.m_sda_oe), .d_sda_oe(link.d_sda_oe), .d_alert_oe(link.d_alert_oe),
    .scl(link.scl), .sda(link.sda), .alert_n(link.alert_n));

  always #12.5 core_clk = ~core_clk;

  // strobes are one cycle wide, so hold what they carried
  always @(posedge core_clk) begin
    if (rx_valid === 1'b1) rx_last <= rx_data;
    if (gc_reset === 1'b1) gc_seen <= 1'b1;
  end

  // ****************************************************************
  // access tasks
  // ****************************************************************
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // apb transfer; waits on pready, the watchdog catches a dead slave
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk);
    while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // issue one link command and poll until the controller is idle
  task cmd(input logic [1:0] c, input logic [7:0] d, input logic nk);
    apb(1'b1, `SAG_CTRL_OFS, {21'h0, nk, c, d});
    do apb(1'b0, `SAG_STAT_OFS, 32'h0);
    while (r[`SAG_STAT_BUSY_BIT] !== 1'b0);
    st = r;
  endtask

  task frame(input logic [7:0] a, input logic [7:0] b, input logic na, input logic nb);
    cmd(SC_START, 8'h00, 1'b0);
    cmd(SC_WRITE, a, 1'b0);
    chk(st[`SAG_STAT_NACK_BIT], na);
    cmd(SC_WRITE, b, 1'b0);
    chk(st[`SAG_STAT_NACK_BIT], nb);
    cmd(SC_STOP, 8'h00, 1'b0);
  endtask

  task ara(input logic ack, input logic [7:0] exp);
    cmd(SC_START, 8'h00, 1'b0);
    cmd(SC_WRITE, `SAG_ARA_BYTE, 1'b0);
    chk(st[`SAG_STAT_NACK_BIT], !ack);
    if (ack) begin
      cmd(SC_READ, 8'h00, 1'b1);
      chk(st[7:0], exp);
    end
    cmd(SC_STOP, 8'h00, 1'b0);
  endtask

  task cfg(input logic m, input logic p);
    @(posedge core_clk);
    cfg_mode <= m;
    cfg_pol <= p;
    cfg_wr <= 1'b1;
    @(posedge core_clk);
    cfg_wr <= 1'b0;
  endtask

  task fire(input logic c);
    @(posedge core_clk);
    cause_low <= c;
    alert_set <= 1'b1;
    @(posedge core_clk);
    alert_set <= 1'b0;
  endtask

  task alert_is(input logic v);
    repeat (3) @(posedge core_clk);
    apb(1'b0, `SAG_STAT_OFS, 32'h0);
    chk(r[`SAG_STAT_ALERT_BIT], v);
  endtask

  task complete_run;
    if (fails == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  initial begin
    {core_clk, rst_n, psel, penable, pwrite, cfg_wr, cfg_mode, cfg_pol} = '0;
    {alert_set, cause_low, reg_read, shutdown, gc_seen} = '0;
    {paddr, pwdata, pin_a, pin_b, rx_last} = '0;
    tx_data = 8'h3C;
    fails = 0;
    n_compared = 0;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    frame(8'h90, 8'hA5, 1'b0, 1'b0);
    chk(rx_last, 8'hA5);
    cmd(SC_START, 8'h00, 1'b0);
    cmd(SC_WRITE, 8'h91, 1'b0);
    cmd(SC_READ, 8'h00, 1'b0);
    chk(st[7:0], 8'h3C);
    cmd(SC_READ, 8'h00, 1'b1);
    chk(st[7:0], 8'h3C);
    cmd(SC_STOP, 8'h00, 1'b0);
    ara(1'b0, 8'h00);
    cfg(1'b0, 1'b0);
    fire(1'b0);
    alert_is(1'b0);
    // every polarity and cause pairing of the reply bit
    for (i = 0; i < 4; i++) begin
      cfg(1'b1, i[0]);
      fire(i[1]);
      alert_is(1'b1);
      ara(1'b1, {7'h48, i[0] ^ i[1]});
      alert_is(1'b0);
    end
    fire(1'b0);
    @(posedge core_clk);
    reg_read <= 1'b1;
    @(posedge core_clk);
    reg_read <= 1'b0;
    alert_is(1'b0);
    fire(1'b1);
    @(posedge core_clk);
    shutdown <= 1'b1;
    alert_is(1'b0);
    shutdown <= 1'b0;
    fire(1'b0);
    pin_a <= `SAG_PIN_HI;
    frame(`SAG_GC_BYTE, `SAG_GC_LATCH, 1'b0, 1'b0);
    chk(slave_addr, 7'h4A);
    chk({mode_o, alert_act}, 2'h3);
    frame(8'h01, 8'h00, 1'b1, 1'b1);
    frame(`SAG_GC_BYTE, `SAG_GC_RESET, 1'b0, 1'b0);
    chk({gc_seen, mode_o, pol_o, alert_act, link.alert_n}, 5'h11);
    cmd(SC_START, 8'h00, 1'b0);
    cmd(SC_WRITE, 8'h0B, 1'b0);
    chk(st[`SAG_STAT_NACK_BIT], 1'b1);
    chk({st[`SAG_STAT_HS_BIT], hs_o}, 2'h3);
    cmd(SC_START, 8'h00, 1'b0);
    cmd(SC_WRITE, 8'h94, 1'b0);
    chk(st[`SAG_STAT_NACK_BIT], 1'b0);
    cmd(SC_STOP, 8'h00, 1'b0);
    repeat (8) @(posedge core_clk); // device sees the stop late
    chk({st[`SAG_STAT_HS_BIT], hs_o}, 2'h0);
    complete_run;
  end

  // watchdog, well above the expected run length
  initial begin
    #2500000;
    fails++;
    complete_run;
  end
endmodule
